/* File: verilog/nfo_pkg.sv */
// Purpose: Shared constants and types for the next-instruction field override block.
// Assumes: 32-bit instruction word with 9-bit D and S fields; core clock only.
// Notes: Field positions of the substitute select code are adjustable here.

`default_nettype none

package nfo_pkg;

    // ************************************************************
    // Instruction word layout
    // ************************************************************
    localparam int NFO_W = 32;
    localparam int NFO_FLD_W = 9;
    localparam int NFO_S_LSB = 0;
    localparam int NFO_D_LSB = 9;
    localparam int NFO_I_LSB = 18;
    localparam int NFO_AUG_W = 23;
    localparam int NFO_SEL_W = 3;
    localparam int NFO_STEP_LSB = 9;

    // ************************************************************
    // Register slices used by the overrides
    // ************************************************************
    localparam int NFO_BIT_IDX_LSB = 5;
    localparam int NFO_BYTE_ADR_LSB = 2;
    localparam int NFO_NIB_ADR_LSB = 3;
    localparam int NFO_WORD_ADR_LSB = 1;

    // Default select bits inside S for the two-operand substitute
    localparam int NFO_SUB_SEL_S_BIT = 0;
    localparam int NFO_SUB_SEL_D_BIT = 1;
    localparam int NFO_SUB_SEL_R_BIT = 2;
    localparam int NFO_SUB_SEL_I_BIT = 3;

    // Prefix operation presented by decode
    typedef enum logic [3:0] {
        NFO_OP_NONE,
        NFO_OP_BIT_IDX,
        NFO_OP_DEST,
        NFO_OP_SRC,
        NFO_OP_RESULT,
        NFO_OP_BYTE_EXT,
        NFO_OP_NIB_EXT,
        NFO_OP_WORD_EXT,
        NFO_OP_BYTE_INS,
        NFO_OP_NIB_INS,
        NFO_OP_WORD_INS,
        NFO_OP_WHOLE,
        NFO_OP_AUG_D,
        NFO_OP_AUG_S
    } nfo_op_type;

    // Class of the following instruction, for the selector overrides
    typedef enum logic [2:0] {
        NFO_CLS_OTHER,
        NFO_CLS_BYTE_EXT,
        NFO_CLS_NIB_EXT,
        NFO_CLS_WORD_EXT,
        NFO_CLS_BYTE_INS,
        NFO_CLS_NIB_INS,
        NFO_CLS_WORD_INS
    } nfo_cls_type;

endpackage : nfo_pkg

`default_nettype wire

/* File: verilog/nfo_core.sv */
// Purpose: Prefix logic that rewrites fields of the following instruction.
// Assumes: Decode presents each prefix and each following instruction as one-cycle pulses.
// Notes: Rewritten instruction and register write-back appear one clock after the pulse.

`default_nettype none

module nfo_core #(
    parameter int SEL_S_BIT = nfo_pkg::NFO_SUB_SEL_S_BIT, // Substitute S-field select bit
    parameter int SEL_D_BIT = nfo_pkg::NFO_SUB_SEL_D_BIT, // Substitute D-field select bit
    parameter int SEL_R_BIT = nfo_pkg::NFO_SUB_SEL_R_BIT, // Substitute result select bit
    parameter int SEL_I_BIT = nfo_pkg::NFO_SUB_SEL_I_BIT  // Substitute I-field select bit
) (
    input wire logic clk_i, // Core clock
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic pfx_valid_i, // Prefix executes this cycle
    input wire nfo_pkg::nfo_op_type pfx_op_i, // Which prefix
    input wire logic pfx_two_op_i, // Prefix has an S operand
    input wire logic [nfo_pkg::NFO_W-1:0] pfx_d_i, // Prefix register value
    input wire logic [nfo_pkg::NFO_W-1:0] pfx_s_i, // Prefix S operand value
    input wire logic [nfo_pkg::NFO_AUG_W-1:0] pfx_aug_i, // Extension constant
    input wire logic nxt_valid_i, // Following instruction decodes
    input wire logic [nfo_pkg::NFO_W-1:0] nxt_instr_i, // Following instruction word
    input wire nfo_pkg::nfo_cls_type nxt_cls_i, // Class of following instruction
    input wire logic nxt_d_imm_i, // Following uses immediate D
    input wire logic nxt_s_imm_i, // Following uses immediate S
    output logic out_valid_o, // Rewritten instruction valid
    output logic [nfo_pkg::NFO_W-1:0] out_instr_o, // Rewritten instruction
    output logic [nfo_pkg::NFO_FLD_W-1:0] out_res_addr_o, // Result register address
    output logic [nfo_pkg::NFO_SEL_W-1:0] out_sel_o, // Byte/nibble/word selector
    output logic out_sel_en_o, // Selector override active
    output logic [nfo_pkg::NFO_W-1:0] out_d_imm_o, // Widened immediate D
    output logic [nfo_pkg::NFO_W-1:0] out_s_imm_o, // Widened immediate S
    output logic wb_valid_o, // Prefix register write-back
    output logic [nfo_pkg::NFO_W-1:0] wb_data_o // Prefix register new value
);
    import nfo_pkg::*;

    // ************************************************************
    // Decode of the prefix into pending fields
    // ************************************************************
    logic [NFO_FLD_W-1:0] s9;
    logic [NFO_FLD_W-1:0] n_d;
    logic [NFO_FLD_W-1:0] n_s;
    logic [NFO_FLD_W-1:0] n_r;
    logic [NFO_SEL_W-1:0] n_sel;
    nfo_cls_type n_cls;
    logic n_d_en;
    logic n_s_en;
    logic n_r_en;
    logic n_sel_en;
    logic n_whole;
    logic [3:0] n_mask;
    logic [NFO_W-1:0] step;

    assign s9 = pfx_s_i[NFO_FLD_W-1:0];
    assign step = {{(NFO_W-NFO_FLD_W){pfx_s_i[NFO_STEP_LSB+NFO_FLD_W-1]}},
                   pfx_s_i[NFO_STEP_LSB +: NFO_FLD_W]};

    // Address is the slice alone, or slice plus S folded to nine bits
    always_comb begin
        n_d = '0;
        n_s = '0;
        n_r = '0;
        n_sel = '0;
        n_cls = NFO_CLS_OTHER;
        n_d_en = 1'b0;
        n_s_en = 1'b0;
        n_r_en = 1'b0;
        n_sel_en = 1'b0;
        n_whole = 1'b0;
        n_mask = '0;
        unique case (pfx_op_i)
            NFO_OP_BIT_IDX: begin
                n_d_en = 1'b1;
                n_d = pfx_d_i[NFO_BIT_IDX_LSB +: NFO_FLD_W];
                if (pfx_two_op_i) begin
                    n_d = pfx_d_i[NFO_BIT_IDX_LSB +: NFO_FLD_W] + s9;
                end
            end
            NFO_OP_DEST: begin
                n_d_en = 1'b1;
                n_d = pfx_two_op_i ? pfx_d_i[NFO_FLD_W-1:0] + s9 : pfx_d_i[NFO_FLD_W-1:0];
            end
            NFO_OP_SRC: begin
                n_s_en = 1'b1;
                n_s = pfx_two_op_i ? pfx_d_i[NFO_FLD_W-1:0] + s9 : pfx_d_i[NFO_FLD_W-1:0];
            end
            NFO_OP_RESULT: begin
                n_r_en = 1'b1;
                n_r = pfx_two_op_i ? pfx_d_i[NFO_FLD_W-1:0] + s9 : pfx_d_i[NFO_FLD_W-1:0];
            end
            NFO_OP_BYTE_EXT: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_BYTE_EXT;
                n_s = pfx_d_i[NFO_BYTE_ADR_LSB +: NFO_FLD_W];
                n_sel = {1'b0, pfx_d_i[NFO_BYTE_ADR_LSB-1:0]};
            end
            NFO_OP_NIB_EXT: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_NIB_EXT;
                n_s = pfx_d_i[NFO_NIB_ADR_LSB +: NFO_FLD_W];
                n_sel = pfx_d_i[NFO_NIB_ADR_LSB-1:0];
            end
            NFO_OP_WORD_EXT: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_WORD_EXT;
                n_s = pfx_d_i[NFO_WORD_ADR_LSB +: NFO_FLD_W];
                n_sel = {2'h0, pfx_d_i[NFO_WORD_ADR_LSB-1]};
            end
            NFO_OP_BYTE_INS: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_BYTE_INS;
                n_d = pfx_d_i[NFO_BYTE_ADR_LSB +: NFO_FLD_W];
                n_sel = {1'b0, pfx_d_i[NFO_BYTE_ADR_LSB-1:0]};
            end
            NFO_OP_NIB_INS: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_NIB_INS;
                n_d = pfx_d_i[NFO_NIB_ADR_LSB +: NFO_FLD_W];
                n_sel = pfx_d_i[NFO_NIB_ADR_LSB-1:0];
            end
            NFO_OP_WORD_INS: begin
                n_sel_en = 1'b1;
                n_cls = NFO_CLS_WORD_INS;
                n_d = pfx_d_i[NFO_WORD_ADR_LSB +: NFO_FLD_W];
                n_sel = {2'h0, pfx_d_i[NFO_WORD_ADR_LSB-1]};
            end
            NFO_OP_WHOLE: begin
                n_whole = 1'b1;
                n_mask = 4'hf;
                if (pfx_two_op_i) begin
                    n_mask = {pfx_s_i[SEL_I_BIT], pfx_s_i[SEL_R_BIT],
                              pfx_s_i[SEL_D_BIT], pfx_s_i[SEL_S_BIT]};
                end
            end
            default: begin
            end
        endcase
        // Selector forms add S only to the address part
        if (pfx_two_op_i && n_sel_en) begin
            n_d = n_d + s9;
            n_s = n_s + s9;
        end
    end

    // ************************************************************
    // Pending override, lives until the next instruction decodes
    // ************************************************************
    logic d_en_q, s_en_q, r_en_q, sel_en_q, whole_q;
    logic [NFO_FLD_W-1:0] d_q, s_q, r_q;
    logic [NFO_SEL_W-1:0] sel_q;
    nfo_cls_type cls_q;
    logic [3:0] mask_q;
    logic [NFO_W-1:0] word_q;
    logic fld_set;

    assign fld_set = pfx_valid_i && (pfx_op_i != NFO_OP_AUG_D) && (pfx_op_i != NFO_OP_AUG_S);

    // A new prefix in the same cycle as a consume wins; it targets a later instruction
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            d_en_q <= 1'b0;
            s_en_q <= 1'b0;
            r_en_q <= 1'b0;
            sel_en_q <= 1'b0;
            whole_q <= 1'b0;
            d_q <= '0;
            s_q <= '0;
            r_q <= '0;
            sel_q <= '0;
            cls_q <= NFO_CLS_OTHER;
            mask_q <= '0;
            word_q <= '0;
        end else if (fld_set) begin
            d_en_q <= n_d_en || (n_sel_en && n_cls >= NFO_CLS_BYTE_INS);
            s_en_q <= n_s_en || (n_sel_en && n_cls <= NFO_CLS_WORD_EXT);
            r_en_q <= n_r_en;
            sel_en_q <= n_sel_en;
            whole_q <= n_whole;
            d_q <= n_d;
            s_q <= n_s;
            r_q <= n_r;
            sel_q <= n_sel;
            cls_q <= n_cls;
            mask_q <= n_mask;
            word_q <= pfx_d_i;
        end else if (nxt_valid_i) begin
            d_en_q <= 1'b0;
            s_en_q <= 1'b0;
            r_en_q <= 1'b0;
            sel_en_q <= 1'b0;
            whole_q <= 1'b0;
        end
    end

    // ************************************************************
    // Immediate extensions, held until an immediate consumes them
    // ************************************************************
    logic aug_d_en_q, aug_s_en_q;
    logic [NFO_AUG_W-1:0] aug_d_q, aug_s_q;
    logic set_aug_d, set_aug_s;

    assign set_aug_d = pfx_valid_i && pfx_op_i == NFO_OP_AUG_D;
    assign set_aug_s = pfx_valid_i && pfx_op_i == NFO_OP_AUG_S;

    // Set wins over consume so a fresh extension is never dropped
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            aug_d_en_q <= 1'b0;
            aug_s_en_q <= 1'b0;
            aug_d_q <= '0;
            aug_s_q <= '0;
        end else begin
            if (set_aug_d) begin
                aug_d_en_q <= 1'b1;
                aug_d_q <= pfx_aug_i;
            end else if (nxt_valid_i && nxt_d_imm_i) begin
                aug_d_en_q <= 1'b0;
            end
            if (set_aug_s) begin
                aug_s_en_q <= 1'b1;
                aug_s_q <= pfx_aug_i;
            end else if (nxt_valid_i && nxt_s_imm_i) begin
                aug_s_en_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Rewrite of the following instruction
    // ************************************************************
    logic [NFO_W-1:0] base;
    logic [NFO_W-1:0] word;
    logic [NFO_FLD_W-1:0] res;
    logic sel_hit;

    assign sel_hit = sel_en_q && (nxt_cls_i == cls_q);

    // Fields pulled from the held register word, then address overrides
    always_comb begin
        base = nxt_instr_i;
        word = word_q;
        res = nxt_instr_i[NFO_D_LSB +: NFO_FLD_W];
        if (whole_q) begin
            if (mask_q[3]) begin
                base[NFO_W-1:NFO_I_LSB] = word[NFO_W-1:NFO_I_LSB];
            end
            if (mask_q[1]) begin
                base[NFO_D_LSB +: NFO_FLD_W] = word[NFO_D_LSB +: NFO_FLD_W];
            end
            if (mask_q[0]) begin
                base[NFO_S_LSB +: NFO_FLD_W] = word[NFO_S_LSB +: NFO_FLD_W];
            end
            res = mask_q[2] ? word[NFO_D_LSB +: NFO_FLD_W] : base[NFO_D_LSB +: NFO_FLD_W];
        end
        if (d_en_q && (!sel_en_q || sel_hit)) begin
            base[NFO_D_LSB +: NFO_FLD_W] = d_q;
            res = d_q;
        end
        if (s_en_q && (!sel_en_q || sel_hit)) begin
            base[NFO_S_LSB +: NFO_FLD_W] = s_q;
        end
        if (r_en_q) begin
            res = r_q;
        end
    end

    // Outputs land one clock after the following instruction decodes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_valid_o <= 1'b0;
            out_instr_o <= '0;
            out_res_addr_o <= '0;
            out_sel_o <= '0;
            out_sel_en_o <= 1'b0;
            out_d_imm_o <= '0;
            out_s_imm_o <= '0;
        end else begin
            out_valid_o <= nxt_valid_i;
            if (nxt_valid_i) begin
                out_instr_o <= base;
                out_res_addr_o <= res;
                out_sel_o <= sel_hit ? sel_q : '0;
                out_sel_en_o <= sel_hit;
                out_d_imm_o <= {(aug_d_en_q ? aug_d_q : NFO_AUG_W'(0)),
                                base[NFO_D_LSB +: NFO_FLD_W]};
                out_s_imm_o <= {(aug_s_en_q ? aug_s_q : NFO_AUG_W'(0)),
                                base[NFO_S_LSB +: NFO_FLD_W]};
            end
        end
    end

    // ************************************************************
    // Register auto-advance after two-operand prefixes
    // ************************************************************
    // Single-form substitute never writes back, so its register stays intact
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wb_valid_o <= 1'b0;
            wb_data_o <= '0;
        end else begin
            wb_valid_o <= fld_set && pfx_two_op_i && pfx_op_i != NFO_OP_NONE;
            wb_data_o <= pfx_d_i + step;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // One quiet cycle between prefix and consumer, so nothing else touches the pending state
    sequence quiet_then_nxt;
        !pfx_valid_i && !nxt_valid_i ##1 nxt_valid_i;
    endsequence

    a_bit_idx_single: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_BIT_IDX && !pfx_two_op_i ##1 quiet_then_nxt
        |=> out_instr_o[NFO_D_LSB +: NFO_FLD_W] == $past(pfx_d_i[NFO_BIT_IDX_LSB +: NFO_FLD_W], 3))
        else $error("bit index override D field wrong");
    a_step_wb: assert property (
        pfx_valid_i && pfx_two_op_i && pfx_op_i inside {NFO_OP_DEST, NFO_OP_SRC}
        |=> wb_valid_o && wb_data_o == $past(pfx_d_i) + $past(step))
        else $error("register advance missing or wrong");
    a_dest_single: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_DEST && !pfx_two_op_i ##1 quiet_then_nxt
        |=> out_instr_o[NFO_D_LSB +: NFO_FLD_W] == $past(pfx_d_i[NFO_FLD_W-1:0], 3))
        else $error("dest override wrong");
    a_src_two_op: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_SRC && pfx_two_op_i ##1 quiet_then_nxt
        |=> out_instr_o[NFO_S_LSB +: NFO_FLD_W] ==
            NFO_FLD_W'($past(pfx_d_i, 3) + $past(pfx_s_i, 3)))
        else $error("source override sum wrong");
    a_result_addr: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_RESULT && !pfx_two_op_i ##1 quiet_then_nxt
        |=> out_res_addr_o == $past(pfx_d_i[NFO_FLD_W-1:0], 3))
        else $error("result address override wrong");
    a_byte_ext_sel: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_BYTE_EXT ##1 quiet_then_nxt
        ##0 nxt_cls_i == NFO_CLS_BYTE_EXT
        |=> out_sel_en_o && out_sel_o == {1'b0, $past(pfx_d_i[NFO_BYTE_ADR_LSB-1:0], 3)})
        else $error("byte selector wrong");
    a_whole_kept: assert property (
        pfx_valid_i && pfx_op_i == NFO_OP_WHOLE && !pfx_two_op_i ##1 quiet_then_nxt
        |=> out_instr_o == $past(pfx_d_i, 3) && !$past(wb_valid_o, 2))
        else $error("substitute did not execute register");
    a_aug_dest: assert property (
        set_aug_d ##1 quiet_then_nxt ##0 (nxt_d_imm_i && !set_aug_d)
        |=> out_d_imm_o[NFO_W-1:NFO_FLD_W] == $past(pfx_aug_i, 3) ##1 !aug_d_en_q)
        else $error("destination extension lost");
    a_one_shot: assert property (
        nxt_valid_i && !fld_set |=> !d_en_q && !s_en_q && !r_en_q && !whole_q)
        else $error("override outlived next instruction");

    c_bit_idx: cover property (pfx_valid_i && pfx_op_i == NFO_OP_BIT_IDX ##2 nxt_valid_i);
    c_whole_two: cover property (pfx_valid_i && pfx_op_i == NFO_OP_WHOLE && pfx_two_op_i);
    c_aug_s: cover property (set_aug_s ##[1:4] nxt_valid_i && nxt_s_imm_i);
    c_sel_ins: cover property (sel_hit && cls_q == NFO_CLS_NIB_INS && nxt_valid_i);

endmodule : nfo_core

`default_nettype wire

/* File: verif/nfo_decode_model.sv */
// Purpose: Behavioural model of the decode stage that feeds prefixes and instructions.
// Assumes: One-cycle pulses, driven 1 ns after the rising clock edge.
// Notes: Released data lines show the inverse of the last value, so stale data cannot pass.
`default_nettype none
module nfo_decode_model (
    input wire logic clk_i, // Core clock
    output logic pfx_valid_o, // Prefix pulse
    output nfo_pkg::nfo_op_type pfx_op_o, // Prefix kind
    output logic pfx_two_op_o, // Prefix has S operand
    output logic [31:0] pfx_d_o, // Prefix register value
    output logic [31:0] pfx_s_o, // Prefix S operand
    output logic [22:0] pfx_aug_o, // Extension constant
    output logic nxt_valid_o, // Following instruction pulse
    output logic [31:0] nxt_instr_o, // Following instruction word
    output nfo_pkg::nfo_cls_type nxt_cls_o, // Following class
    output logic nxt_d_imm_o, // Immediate D flag
    output logic nxt_s_imm_o // Immediate S flag
);
    import nfo_pkg::*;
    // Idle values at time zero
    initial begin
        {pfx_valid_o, pfx_two_op_o, pfx_d_o, pfx_s_o, pfx_aug_o} = '0;
        {nxt_valid_o, nxt_instr_o, nxt_d_imm_o, nxt_s_imm_o} = '0;
        pfx_op_o = NFO_OP_NONE;
        nxt_cls_o = NFO_CLS_OTHER;
    end
    // Issue one prefix; held across exactly one sampling edge
    task automatic send_prefix(input nfo_op_type op, input logic two, input logic [31:0] d,
                               input logic [31:0] s, input logic [22:0] aug);
        @(posedge clk_i);
        #1;
        {pfx_valid_o, pfx_two_op_o, pfx_d_o, pfx_s_o, pfx_aug_o} = {1'b1, two, d, s, aug};
        pfx_op_o = op;
        @(posedge clk_i);
        #1;
        {pfx_valid_o, pfx_d_o, pfx_s_o, pfx_aug_o} = {1'b0, ~d, ~s, ~aug};
    endtask : send_prefix
    // Issue one following instruction
    task automatic send_instr(input logic [31:0] ins, input nfo_cls_type cls, input logic di,
                              input logic si);
        @(posedge clk_i);
        #1;
        {nxt_valid_o, nxt_instr_o, nxt_d_imm_o, nxt_s_imm_o} = {1'b1, ins, di, si};
        nxt_cls_o = cls;
        @(posedge clk_i);
        #1;
        {nxt_valid_o, nxt_instr_o, nxt_d_imm_o, nxt_s_imm_o} = {1'b0, ~ins, 1'b0, 1'b0};
    endtask : send_instr
endmodule : nfo_decode_model
`default_nettype wire

/* File: verif/next_instruction_field_override_bench.sv */
// Purpose: Self-checking bench for the next-instruction field override block.
// Assumes: Fixed one-cycle answer latency as handed over by the designer.
// Notes: Expected fields are sliced here from the register value, never read back.
`default_nettype none
module next_instruction_field_override_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import nfo_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    int errors = 0;
    int cmp_count = 0;
    wire logic pfx_valid_i, pfx_two_op_i, nxt_valid_i, nxt_d_imm_i, nxt_s_imm_i;
    wire nfo_op_type pfx_op_i;
    wire nfo_cls_type nxt_cls_i;
    wire logic [31:0] pfx_d_i, pfx_s_i, nxt_instr_i;
    wire logic [22:0] pfx_aug_i;
    logic out_valid_o, out_sel_en_o, wb_valid_o;
    logic [31:0] out_instr_o, out_d_imm_o, out_s_imm_o, wb_data_o;
    logic [8:0] out_res_addr_o;
    logic [2:0] out_sel_o;
    localparam logic [31:0] IN = 32'hc3a5_5a3c;
    always #10 clk_i = ~clk_i;
    nfo_decode_model dec_u (.clk_i(clk_i), .pfx_valid_o(pfx_valid_i), .pfx_op_o(pfx_op_i),
        .pfx_two_op_o(pfx_two_op_i), .pfx_d_o(pfx_d_i), .pfx_s_o(pfx_s_i), .pfx_aug_o(pfx_aug_i),
        .nxt_valid_o(nxt_valid_i), .nxt_instr_o(nxt_instr_i), .nxt_cls_o(nxt_cls_i),
        .nxt_d_imm_o(nxt_d_imm_i), .nxt_s_imm_o(nxt_s_imm_i));
    nfo_core dut_u (.clk_i, .sys_rst_i, .pfx_valid_i, .pfx_op_i, .pfx_two_op_i, .pfx_d_i,
        .pfx_s_i, .pfx_aug_i, .nxt_valid_i, .nxt_instr_i, .nxt_cls_i, .nxt_d_imm_i, .nxt_s_imm_i,
        .out_valid_o, .out_instr_o, .out_res_addr_o, .out_sel_o, .out_sel_en_o, .out_d_imm_o,
        .out_s_imm_o, .wb_valid_o, .wb_data_o);
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] setd(input logic [31:0] i, input logic [8:0] f);
        return {i[31:18], f, i[8:0]};
    endfunction : setd
    function automatic logic [31:0] sets(input logic [31:0] i, input logic [8:0] f);
        return {i[31:9], f};
    endfunction : sets
    // Prefix then one instruction; write-back only for two-operand field prefixes
    task automatic go(input nfo_op_type op, input logic two, input logic [31:0] d, s,
                      input nfo_cls_type cls, input logic di, si, input logic [22:0] aug);
        dec_u.send_prefix(op, two, d, s, aug);
        chk(wb_valid_o, two && !(op inside {NFO_OP_NONE, NFO_OP_AUG_D, NFO_OP_AUG_S}));
        if (wb_valid_o === 1'b1) chk(wb_data_o, d + {{23{s[17]}}, s[17:9]});
        dec_u.send_instr(IN, cls, di, si);
        chk(out_valid_o, 1'b1);
    endtask : go
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_single;
        go(NFO_OP_DEST, 0, 32'hffff_fe05, 0, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, setd(IN, 9'h005));
        dec_u.send_instr(IN, NFO_CLS_OTHER, 0, 0);
        chk(out_instr_o, IN);
        go(NFO_OP_SRC, 0, 32'h0000_0123, 0, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, sets(IN, 9'h123));
        go(NFO_OP_RESULT, 0, 32'h0000_01ab, 0, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_res_addr_o, 9'h1ab);
        go(NFO_OP_BIT_IDX, 0, 32'h0000_3fe0, 0, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, setd(IN, 9'h1ff));
    endtask : t_single
    // Negative step in S[17:9] and a carry out of the 9-bit field
    task automatic t_two_op;
        go(NFO_OP_BIT_IDX, 1, 32'h0000_3fe7, 32'h0003_fe10, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, setd(IN, 9'h00f));
        go(NFO_OP_DEST, 1, 32'h0000_3fe7, 32'h0003_fe10, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, setd(IN, 9'h1f7));
        go(NFO_OP_SRC, 1, 32'h0000_3fe7, 32'h0003_fe10, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, sets(IN, 9'h1f7));
        go(NFO_OP_RESULT, 1, 32'h0000_3fe7, 32'h0003_fe10, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_res_addr_o, 9'h1f7);
    endtask : t_two_op
    // All six selector prefixes, single and two-operand, plus a class mismatch
    task automatic t_select;
        nfo_op_type ops[6] = '{NFO_OP_BYTE_EXT, NFO_OP_NIB_EXT, NFO_OP_WORD_EXT,
                               NFO_OP_BYTE_INS, NFO_OP_NIB_INS, NFO_OP_WORD_INS};
        nfo_cls_type cl[6] = '{NFO_CLS_BYTE_EXT, NFO_CLS_NIB_EXT, NFO_CLS_WORD_EXT,
                               NFO_CLS_BYTE_INS, NFO_CLS_NIB_INS, NFO_CLS_WORD_INS};
        int lsb[6] = '{2, 3, 1, 2, 3, 1};
        logic [31:0] d = 32'h0000_0f5b;
        logic [31:0] s = 32'h0000_0e31;
        logic [8:0] f;
        for (int t = 0; t < 2; t++) begin
            for (int i = 0; i < 6; i++) begin
                f = 9'((d >> lsb[i]) + (t ? s : 32'h0));
                go(ops[i], t[0], d, s, cl[i], 0, 0, 0);
                chk(out_instr_o, (i < 3) ? sets(IN, f) : setd(IN, f));
                chk(out_sel_o, 3'(d & ((1 << lsb[i]) - 1)));
                chk(out_sel_en_o, 1'b1);
            end
        end
        go(NFO_OP_BYTE_EXT, 0, d, s, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, IN);
        chk(out_sel_en_o, 1'b0);
        chk(out_sel_o, 3'h0);
    endtask : t_select
    task automatic t_whole;
        logic [31:0] w = 32'h89ab_cdef;
        go(NFO_OP_WHOLE, 0, w, 0, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, w);
        go(NFO_OP_WHOLE, 1, w, 32'h0000_000f, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, w);
        chk(out_res_addr_o, w[17:9]);
        // Partial selects: S field plus result address, then I and D fields only
        go(NFO_OP_WHOLE, 1, w, 32'h0000_0005, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, sets(IN, w[8:0]));
        chk(out_res_addr_o, w[17:9]);
        go(NFO_OP_WHOLE, 1, w, 32'h0000_000a, NFO_CLS_OTHER, 0, 0, 0);
        chk(out_instr_o, {w[31:9], IN[8:0]});
        chk(out_res_addr_o, w[17:9]);
    endtask : t_whole
    task automatic t_aug;
        go(NFO_OP_AUG_D, 0, 0, 0, NFO_CLS_OTHER, 1, 1, 23'h5a_5a5a);
        chk(out_d_imm_o, {23'h5a_5a5a, IN[17:9]});
        chk(out_s_imm_o, {23'h0, IN[8:0]});
        go(NFO_OP_AUG_S, 0, 0, 0, NFO_CLS_OTHER, 0, 1, 23'h12_3456);
        chk(out_s_imm_o, {23'h12_3456, IN[8:0]});
    endtask : t_aug
    // ************************************************************
    // Sequence and verdict
    // ************************************************************
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk(32'({out_valid_o, wb_valid_o}), 32'h0);
        chk(out_instr_o, 32'h0);
        t_single();
        t_two_op();
        t_select();
        t_whole();
        t_aug();
        finish_test();
    end
    // A hang is cut short here and counted
    initial begin
        #200000;
        errors++;
        finish_test();
    end
endmodule : next_instruction_field_override_bench
`default_nettype wire
